// ===== ctl_host_model.sv
`timescale 1ns/1ps
module ctl_host_model (
  // clock
  input wire logic clock_in,
  // command request
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_wdata_out,
  output logic [7:0] phase_sel_out,
  // read answer
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_wdata_out = 16'h0000;
    phase_sel_out = 8'h00;
  end
  // one whole word per request, entered at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] ph,
                      input logic [15:0] wd, output logic [16:0] rd);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= wr;
    cmd_code_out <= code;
    cmd_wdata_out <= wd;
    phase_sel_out <= ph;
    @(posedge clock_in);
    // released code and data lines carry inverted junk, never the old word
    cmd_valid_out <= 1'b0;
    cmd_code_out <= ~code;
    cmd_wdata_out <= ~wd;
    @(posedge clock_in);
    rd = {rd_valid_in, rd_data_in};
  endtask : xfer
endmodule : ctl_host_model

// ===== ctl_limits.sv
`timescale 1ns/1ps
module ctl_limits (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // decoded command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic [7:0] phase_sel_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  // stacking strap, phases minus one
  input wire logic [ctl_pkg::NPH_W-1:0] phase_count_in,
  // telemetry
  input wire logic [ctl_pkg::NPH*16-1:0] iout_meas_in,
  input wire logic signed [15:0] temp_meas_in,
  // storage engine
  input wire logic nvm_restore_in,
  input wire logic nvm_store_in,
  input wire logic [ctl_pkg::NPH*ctl_pkg::NVM_CUR_W-1:0] nvm_cur_code_in,
  input wire logic [ctl_pkg::NVM_TEMP_W-1:0] nvm_temp_code_in,
  output logic nvm_write_out,
  output logic [ctl_pkg::NPH*ctl_pkg::NVM_CUR_W-1:0] nvm_cur_code_out,
  output logic [ctl_pkg::NVM_TEMP_W-1:0] nvm_temp_code_out,
  // detector results and host alert
  output logic [ctl_pkg::NPH-1:0] ocw_phase_out,
  output logic [ctl_pkg::NPH*ctl_pkg::HW_W-1:0] hw_step_out,
  output logic ot_fault_out,
  output logic alert_b_out
);
  import ctl_pkg::*;

  function automatic logic [NVM_CUR_W-1:0] cur_nvm_code(input logic [15:0] word);
    logic signed [FIX_W-1:0] q;
    q = (ctl_lin_to_fix(word, 1'b0) + (FIX_W'(1) <<< (NVM_CUR_SHIFT - 1))) >>> NVM_CUR_SHIFT;
    if (q < 0) begin
      return '0;
    end else if (q > FIX_W'(NVM_CUR_MAX_CODE)) begin
      return NVM_CUR_W'(NVM_CUR_MAX_CODE);
    end
    return q[NVM_CUR_W-1:0];
  endfunction : cur_nvm_code

  function automatic logic [NVM_TEMP_W-1:0] temp_nvm_code(input logic [15:0] word);
    logic signed [FIX_W-1:0] q;
    q = (ctl_lin_to_fix(word, 1'b0) + (FIX_W'(1) <<< (FIX_FRAC - 1))) >>> FIX_FRAC;
    if (q < 0) begin
      return '0;
    end else if (q > FIX_W'(TEMP_NVM_MAX_C)) begin
      return NVM_TEMP_W'(TEMP_NVM_MAX_C);
    end
    return q[NVM_TEMP_W-1:0];
  endfunction : temp_nvm_code

  function automatic logic [MAN_W-1:0] div_phases(input logic [MAN_W-1:0] man,
                                                  input logic [NPH_W:0] n);
    case (n)
      3'h2: return man >> 1;
      3'h3: return MAN_W'(man / MAN_W'(3));
      3'h4: return man >> 2;
      default: return man;
    endcase
  endfunction : div_phases

  ctl_init_t init_r;
  logic [NPH_W-1:0] phase_cnt_s1_r;
  logic [NPH_W-1:0] phase_cnt_s2_r;
  logic [NPH_W:0] nph;
  logic [15:0] cur_word_r [NPH];
  logic [15:0] temp_word_r;
  logic [NPH-1:0] ocw_sticky_r;
  logic otf_sticky_r;
  logic cml_invalid_r;
  logic [NPH-1:0] ocw_live;
  logic ot_live;
  logic wr_cur;
  logic wr_temp;
  logic wr_clear;
  logic cur_ok;
  logic temp_ok;
  logic bad_write;
  logic all_ph;
  logic [NPH_W-1:0] ph_idx;
  logic [4:0] current_warn_exponent;
  logic [MAN_W-1:0] current_warn_mantissa;
  logic [4:0] temp_fault_exponent;
  logic [MAN_W-1:0] temp_fault_mantissa;
  logic signed [FIX_W-1:0] wr_fix;
  logic signed [FIX_W-1:0] temp_fix;
  logic [MAN_W-1:0] per_phase_man;
  logic [15:0] rd_nxt;
  logic [7:0] status_byte;
  logic [NPH_W+MAN_W:0] stack_man;

  // stacking strap comes from a pin
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      phase_cnt_s1_r <= '0;
      phase_cnt_s2_r <= '0;
    end else begin
      phase_cnt_s1_r <= phase_count_in;
      phase_cnt_s2_r <= phase_cnt_s1_r;
    end
  end

  // write decode and validation
  always_comb begin
    nph = {1'b0, phase_cnt_s2_r} + (NPH_W+1)'(1);
    all_ph = phase_sel_in == PHASE_ALL;
    ph_idx = phase_sel_in[NPH_W-1:0];
    current_warn_exponent = cmd_wdata_in[EXP_MSB:EXP_LSB];
    current_warn_mantissa = cmd_wdata_in[MAN_MSB:0];
    temp_fault_exponent = cmd_wdata_in[EXP_MSB:EXP_LSB];
    temp_fault_mantissa = cmd_wdata_in[MAN_MSB:0];
    wr_fix = ctl_lin_to_fix(cmd_wdata_in, 1'b1);
    wr_cur = 1'b0;
    wr_temp = 1'b0;
    wr_clear = 1'b0;
    if (cmd_valid_in && cmd_write_in && cmd_code_in == CMD_CUR_WARN) begin
      wr_cur = 1'b1;
    end else if (cmd_valid_in && cmd_write_in && cmd_code_in == CMD_TEMP_FAULT) begin
      wr_temp = 1'b1;
    end else if (cmd_valid_in && cmd_write_in && cmd_code_in == CMD_CLEAR_FAULTS) begin
      wr_clear = 1'b1;
    end
    // the ceiling scales with the stack when all phases are addressed
    cur_ok = !current_warn_mantissa[MAN_MSB] &&
             (all_ph ? wr_fix <= ctl_fix_of(CUR_PHASE_MAX_A * int'(nph))
                     : wr_fix <= ctl_fix_of(CUR_PHASE_MAX_A));
    cur_ok = cur_ok && (all_ph || phase_sel_in < 8'(nph));
    temp_ok = wr_fix == ctl_fix_of(TEMP_DISABLE_C) ||
              (!temp_fault_mantissa[MAN_MSB] && wr_fix <= ctl_fix_of(TEMP_NVM_MAX_C));
    bad_write = (wr_cur && !cur_ok) || (wr_temp && !temp_ok);
    per_phase_man = div_phases(current_warn_mantissa, nph);
  end

  // power-up load then run
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      init_r <= CTL_INIT_LOAD;
    end else begin
      case (init_r)
        CTL_INIT_LOAD: init_r <= CTL_INIT_RUN;
        default: init_r <= CTL_INIT_RUN;
      endcase
    end
  end

  // per-phase current warning thresholds
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int p = 0; p < NPH; p++) begin
        cur_word_r[p] <= {CUR_EXP_RST, {MAN_W{1'b0}}};
      end
    end else if (init_r == CTL_INIT_LOAD || nvm_restore_in) begin
      for (int p = 0; p < NPH; p++) begin
        cur_word_r[p] <= {CUR_EXP_RST,
                          MAN_W'(nvm_cur_code_in[p*NVM_CUR_W +: NVM_CUR_W])};
      end
    end else if (nvm_store_in) begin
      for (int p = 0; p < NPH; p++) begin
        cur_word_r[p] <= {CUR_EXP_RST, MAN_W'(cur_nvm_code(cur_word_r[p]))};
      end
    end else if (wr_cur && cur_ok && all_ph) begin
      for (int p = 0; p < NPH; p++) begin
        cur_word_r[p] <= {current_warn_exponent, per_phase_man};
      end
    end else if (wr_cur && cur_ok) begin
      cur_word_r[ph_idx] <= {current_warn_exponent, current_warn_mantissa};
    end
  end

  // temperature fault threshold, shared by all phases
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      temp_word_r <= {TEMP_EXP_RST, {MAN_W{1'b0}}};
    end else if (init_r == CTL_INIT_LOAD || nvm_restore_in) begin
      temp_word_r <= {TEMP_EXP_RST, MAN_W'(nvm_temp_code_in)};
    end else if (nvm_store_in) begin
      temp_word_r <= {TEMP_EXP_RST, MAN_W'(temp_nvm_code(temp_word_r))};
    end else if (wr_temp && temp_ok) begin
      temp_word_r <= {temp_fault_exponent, temp_fault_mantissa};
    end
  end

  // storage write-back
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      nvm_write_out <= 1'b0;
      nvm_cur_code_out <= '0;
      nvm_temp_code_out <= '0;
    end else begin
      nvm_write_out <= nvm_store_in && init_r == CTL_INIT_RUN;
      if (nvm_store_in) begin
        for (int p = 0; p < NPH; p++) begin
          nvm_cur_code_out[p*NVM_CUR_W +: NVM_CUR_W] <= cur_nvm_code(cur_word_r[p]);
        end
        nvm_temp_code_out <= temp_nvm_code(temp_word_r);
      end
    end
  end

  // per-phase comparators
  for (genvar g = 0; g < NPH; g++) begin : g_phase
    ctl_phase_warn u_warn (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .limit_word_in(cur_word_r[g]),
      .iout_meas_in(iout_meas_in[g*16 +: 16]),
      .warn_out(ocw_live[g]),
      .hw_step_out(hw_step_out[g*HW_W +: HW_W])
    );
  end

  // temperature compare with the written word truncated to FIX_FRAC fraction bits
  always_comb begin
    temp_fix = ctl_lin_to_fix(temp_word_r, 1'b0);
    // signed compare so that sub-zero readings never trip the fault
    ot_live = temp_fix != ctl_fix_of(TEMP_DISABLE_C) &&
              FIX_W'(temp_meas_in) >= temp_fix;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ot_fault_out <= 1'b0;
      ocw_phase_out <= '0;
    end else begin
      ot_fault_out <= ot_live && init_r == CTL_INIT_RUN;
      ocw_phase_out <= ocw_live & {NPH{init_r == CTL_INIT_RUN}};
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ocw_sticky_r <= '0;
      otf_sticky_r <= 1'b0;
      cml_invalid_r <= 1'b0;
    end else begin
      ocw_sticky_r <= ocw_phase_out | (ocw_sticky_r & {NPH{!wr_clear}});
      otf_sticky_r <= ot_fault_out | (otf_sticky_r & !wr_clear);
      cml_invalid_r <= bad_write | (cml_invalid_r & !wr_clear);
    end
  end

  // alert line follows the sticky status
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      alert_b_out <= 1'b1;
    end else begin
      alert_b_out <= !(|ocw_sticky_r || otf_sticky_r || cml_invalid_r);
    end
  end

  // read path; word reads return the full 16-bit value
  always_comb begin
    status_byte = '0;
    status_byte[SB_NOTA] = |ocw_sticky_r;
    status_byte[SB_CML] = cml_invalid_r;
    status_byte[SB_TEMP] = otf_sticky_r;
    stack_man = (NPH_W+MAN_W+1)'(cur_word_r[0][MAN_MSB:0]) * (NPH_W+MAN_W+1)'(nph);
    rd_nxt = '0;
    if (cmd_code_in == CMD_CUR_WARN && all_ph) begin
      rd_nxt[15:EXP_LSB] = cur_word_r[0][EXP_MSB:EXP_LSB];
      rd_nxt[MAN_MSB:0] = stack_man > (NPH_W+MAN_W+1)'(MAN_MAX) ? MAN_MAX
                                                                 : stack_man[MAN_W-1:0];
    end else if (cmd_code_in == CMD_CUR_WARN) begin
      rd_nxt = cur_word_r[ph_idx];
    end else if (cmd_code_in == CMD_TEMP_FAULT) begin
      rd_nxt = temp_word_r;
    end else if (cmd_code_in == CMD_STATUS_BYTE) begin
      rd_nxt = {8'h00, status_byte};
    end else if (cmd_code_in == CMD_STATUS_WORD) begin
      rd_nxt = {8'h00, status_byte};
      rd_nxt[SW_IOUT] = |ocw_sticky_r;
    end else if (cmd_code_in == CMD_STATUS_IOUT) begin
      rd_nxt[SI_OCW] = all_ph ? |ocw_sticky_r : ocw_sticky_r[ph_idx];
    end else if (cmd_code_in == CMD_STATUS_TEMP) begin
      rd_nxt[ST_OTF] = otf_sticky_r;
    end else if (cmd_code_in == CMD_STATUS_CML) begin
      rd_nxt[SC_INVALID] = cml_invalid_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= cmd_valid_in && !cmd_write_in;
      if (cmd_valid_in && !cmd_write_in) begin
        rd_data_out <= rd_nxt;
      end
    end
  end
endmodule : ctl_limits

// ===== ctl_limits_properties.sv
`timescale 1ns/1ps
module ctl_limits_properties (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic rd_valid_out,
  // storage engine
  input wire logic nvm_store_in,
  input wire logic nvm_write_out,
  input wire logic [ctl_pkg::NPH*ctl_pkg::NVM_CUR_W-1:0] nvm_cur_code_out,
  input wire logic [ctl_pkg::NVM_TEMP_W-1:0] nvm_temp_code_out,
  // detectors and alert
  input wire logic [ctl_pkg::NPH-1:0] ocw_phase_out,
  input wire logic [ctl_pkg::NPH*ctl_pkg::HW_W-1:0] hw_step_out,
  input wire logic ot_fault_out,
  input wire logic alert_b_out
);
  import ctl_pkg::*;
  logic rd_req, clr_req, cur_ok, step_ok;
  assign rd_req = cmd_valid_in && !cmd_write_in;
  assign clr_req = cmd_valid_in && cmd_write_in && cmd_code_in == CMD_CLEAR_FAULTS;
  always_comb begin
    cur_ok = 1'b1;
    step_ok = 1'b1;
    for (int p = 0; p < NPH; p++) begin
      if (int'(nvm_cur_code_out[p*NVM_CUR_W +: NVM_CUR_W]) > NVM_CUR_MAX_CODE) cur_ok = 1'b0;
      if (int'(hw_step_out[p*HW_W +: HW_W]) < HW_MIN_A) step_ok = 1'b0;
      if (int'(hw_step_out[p*HW_W +: HW_W]) > CUR_PHASE_MAX_A) step_ok = 1'b0;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // two cycles with no clear request, the alert low in the second
  sequence no_clear_s;
    !clr_req ##1 (!alert_b_out && !clr_req);
  endsequence
  a_read_answer: assert property (rd_req |=> rd_valid_out)
    else $error("read request without answer");
  a_read_cause: assert property (rd_valid_out |-> $past(rd_req))
    else $error("answer without read request");
  a_ocw_alert: assert property ((|ocw_phase_out) |-> ##2 !alert_b_out)
    else $error("warning did not raise alert");
  a_ot_alert: assert property (ot_fault_out |-> ##2 !alert_b_out)
    else $error("fault did not raise alert");
  a_alert_sticky: assert property (no_clear_s |=> !alert_b_out)
    else $error("alert released without clear");
  a_store_write: assert property (nvm_store_in |=> nvm_write_out)
    else $error("store without storage write");
  a_write_cause: assert property (nvm_write_out |-> $past(nvm_store_in))
    else $error("storage write without store");
  a_temp_clamp: assert property (nvm_write_out |-> int'(nvm_temp_code_out) <= TEMP_NVM_MAX_C)
    else $error("stored temperature above range");
  a_cur_clamp: assert property (nvm_write_out |-> cur_ok)
    else $error("stored current above range");
  a_step_range: assert property (step_ok)
    else $error("hardware step outside range");
endmodule : ctl_limits_properties

bind ctl_limits ctl_limits_properties chk_u (
  .clock_in, .rst_b_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in, .rd_valid_out,
  .nvm_store_in, .nvm_write_out, .nvm_cur_code_out, .nvm_temp_code_out,
  .ocw_phase_out, .hw_step_out, .ot_fault_out, .alert_b_out
);

// ===== ctl_phase_warn.sv
`timescale 1ns/1ps
module ctl_phase_warn (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // threshold and telemetry
  input wire logic [15:0] limit_word_in,
  input wire logic [15:0] iout_meas_in,
  // comparator results
  output logic warn_out,
  output logic [ctl_pkg::HW_W-1:0] hw_step_out
);
  import ctl_pkg::*;

  logic signed [FIX_W-1:0] lim_fix;
  logic signed [FIX_W-1:0] amps_up;
  logic [HW_W-1:0] hw_step_nxt;
  logic signed [FIX_W-1:0] meas_fix;

  always_comb begin
    lim_fix = ctl_lin_to_fix(limit_word_in, 1'b1);
    // between steps goes to the next higher whole amp
    amps_up = (lim_fix + ctl_fix_of(1) - FIX_W'(1)) >>> FIX_FRAC;
    if (amps_up < FIX_W'(HW_MIN_A)) begin
      hw_step_nxt = HW_W'(HW_MIN_A);
    end else if (amps_up > FIX_W'(CUR_PHASE_MAX_A)) begin
      hw_step_nxt = HW_W'(CUR_PHASE_MAX_A);
    end else begin
      hw_step_nxt = amps_up[HW_W-1:0];
    end
    meas_fix = {{(FIX_W-16){1'b0}}, iout_meas_in};
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      hw_step_out <= HW_W'(HW_MIN_A);
    end else begin
      hw_step_out <= hw_step_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      warn_out <= 1'b0;
    end else begin
      warn_out <= meas_fix > ctl_fix_of(int'(hw_step_out));
    end
  end
endmodule : ctl_phase_warn

// ===== ctl_pkg.sv
package ctl_pkg;
  // phases and fixed-point format
  localparam int NPH = 4;
  localparam int NPH_W = 2;
  localparam int FIX_W = 40;
  localparam int FIX_FRAC = 8;
  localparam int MAN_W = 11;
  localparam int HW_W = 5;
  localparam int NVM_CUR_W = 7;
  localparam int NVM_TEMP_W = 8;
  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_CUR_WARN = 8'h4a;
  localparam logic [7:0] CMD_TEMP_FAULT = 8'h4f;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
  localparam logic [7:0] PHASE_ALL = 8'hff;
  // linear word fields
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [4:0] CUR_EXP_RST = 5'h1e;
  localparam logic [4:0] TEMP_EXP_RST = 5'h00;
  localparam logic [MAN_W-1:0] MAN_MAX = 11'h3ff;
  // limits in whole units; storage current codes in quarter-amp steps
  localparam int CUR_PHASE_MAX_A = 23;
  localparam int HW_MIN_A = 4;
  localparam int NVM_STEPS_PER_A = 4;
  localparam int NVM_CUR_MAX_CODE = CUR_PHASE_MAX_A * NVM_STEPS_PER_A;
  localparam int NVM_CUR_SHIFT = 6;
  localparam int TEMP_NVM_MAX_C = 160;
  localparam int TEMP_DISABLE_C = 255;
  // status bit positions
  localparam int SB_NOTA = 0;
  localparam int SB_CML = 1;
  localparam int SB_TEMP = 2;
  localparam int SW_IOUT = 14;
  localparam int SI_OCW = 5;
  localparam int ST_OTF = 7;
  localparam int SC_INVALID = 6;

  typedef enum logic {
    CTL_INIT_LOAD = 1'b0,
    CTL_INIT_RUN = 1'b1
  } ctl_init_t;

  function automatic logic signed [FIX_W-1:0] ctl_fix_of(input int units);
    return FIX_W'(units) <<< FIX_FRAC;
  endfunction : ctl_fix_of

  // linear word to signed fixed point with FIX_FRAC fraction bits
  function automatic logic signed [FIX_W-1:0] ctl_lin_to_fix(input logic [15:0] word,
                                                            input logic round_up);
    logic signed [4:0] e;
    logic signed [FIX_W-1:0] m;
    logic signed [FIX_W-1:0] r;
    int sh;
    e = word[EXP_MSB:EXP_LSB];
    m = {{(FIX_W-MAN_W){word[MAN_MSB]}}, word[MAN_MSB:0]};
    sh = int'(e) + FIX_FRAC;
    if (sh >= 0) begin
      r = m <<< sh;
    end else if (round_up && m > 0) begin
      r = (m + ((FIX_W'(1) <<< (-sh)) - FIX_W'(1))) >>> (-sh);
    end else begin
      r = m >>> (-sh);
    end
    return r;
  endfunction : ctl_lin_to_fix
endpackage : ctl_pkg

// ===== test_ctl_limits.sv
`timescale 1ns/1ps
module test_ctl_limits;
  import ctl_pkg::*;
  typedef struct {
    logic [7:0] code;
    logic [7:0] ph;
    logic [15:0] wd;
    logic [4:0] step;
  } ctl_row_t;
  logic clock_in, rst_b_in, cmd_valid, cmd_write, rd_valid, nvm_restore, nvm_store;
  logic nvm_write, ot_fault, alert_b;
  logic [7:0] cmd_code, phase_sel, nvm_temp_in, nvm_temp_out;
  logic [15:0] cmd_wdata, rd_data;
  logic signed [15:0] temp_meas;
  logic [1:0] phase_count;
  logic [63:0] iout_meas;
  logic [27:0] nvm_cur_in, nvm_cur_out;
  logic [3:0] ocw;
  logic [19:0] hw_step;
  logic [16:0] rd;
  int miscompares, n_compared;
  ctl_row_t rows [6] = '{'{8'h4a, 8'h00, 16'hf02a, 5'd11}, '{8'h4a, 8'h01, 16'h0017, 5'd23},
    '{8'h4a, 8'h02, 16'hf008, 5'd4}, '{8'h4a, 8'h03, 16'h0007, 5'd7},
    '{8'h4f, 8'h00, 16'hf8c9, 5'd0}, '{8'h4f, 8'h00, 16'h00ff, 5'd0}};

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  ctl_host_model host_u (.clock_in, .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
    .cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata), .phase_sel_out(phase_sel),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid));
  ctl_limits dut_u (.clock_in, .rst_b_in, .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata), .phase_sel_in(phase_sel),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .phase_count_in(phase_count),
    .iout_meas_in(iout_meas), .temp_meas_in(temp_meas), .nvm_restore_in(nvm_restore),
    .nvm_store_in(nvm_store), .nvm_cur_code_in(nvm_cur_in), .nvm_temp_code_in(nvm_temp_in),
    .nvm_write_out(nvm_write), .nvm_cur_code_out(nvm_cur_out), .nvm_temp_code_out(nvm_temp_out),
    .ocw_phase_out(ocw), .hw_step_out(hw_step), .ot_fault_out(ot_fault), .alert_b_out(alert_b));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] code, input logic [7:0] ph, input logic [15:0] wd);
    host_u.xfer(1'b1, code, ph, wd, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] code, input logic [7:0] ph, input logic [15:0] exp);
    host_u.xfer(1'b0, code, ph, 16'h0000, rd);
    chk(rd, {1'b1, exp});
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : idle

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    idle(20000);
    miscompares++;
    end_of_test();
  end

  initial begin
    miscompares = 0;
    n_compared = 0;
    rst_b_in = 1'b0;
    phase_count = 2'h3;
    iout_meas = 64'h0;
    temp_meas = 16'sh1900;
    nvm_restore = 1'b0;
    nvm_store = 1'b0;
    nvm_cur_in = {7'd8, 7'd16, 7'd41, 7'd40};
    nvm_temp_in = 8'd100;
    idle(16);
    chk({alert_b, ocw, ot_fault, rd_valid, nvm_write, hw_step}, {1'b1, 7'h00, {4{5'd4}}});
    rst_b_in <= 1'b1;
    idle(4);
    chk(hw_step, {5'd4, 5'd4, 5'd11, 5'd10});
    rdchk(CMD_CUR_WARN, 8'h00, 16'hf028);
    rdchk(CMD_CUR_WARN, 8'h03, 16'hf008);
    rdchk(CMD_TEMP_FAULT, 8'h00, 16'h0064);
    rdchk(8'h4c, 8'h00, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].code, rows[i].ph, rows[i].wd);
      rdchk(rows[i].code, rows[i].ph, rows[i].wd);
      if (rows[i].step != 5'd0) chk(hw_step[5*int'(rows[i].ph) +: 5], rows[i].step);
    end
    // only phase 2 exceeds; phases 0 and 3 sit exactly on their steps
    iout_meas <= {16'h0700, 16'h0401, 16'h0000, 16'h0b00};
    idle(6);
    chk(ocw, 4'h4);
    chk(alert_b, 1'b0);
    rdchk(CMD_STATUS_BYTE, 8'h00, 16'h0001);
    rdchk(CMD_STATUS_WORD, 8'h00, 16'h4001);
    rdchk(CMD_STATUS_IOUT, 8'h02, 16'h0020);
    rdchk(CMD_STATUS_IOUT, 8'h00, 16'h0000);
    iout_meas <= 64'h0;
    idle(4);
    chk(ocw, 4'h0);
    rdchk(CMD_STATUS_BYTE, 8'h00, 16'h0001);
    wr(CMD_CLEAR_FAULTS, 8'h00, 16'h0000);
    idle(3);
    chk(alert_b, 1'b1);
    rdchk(CMD_STATUS_WORD, 8'h00, 16'h0000);
    temp_meas <= 16'sh7f00;
    idle(3);
    chk(ot_fault, 1'b0);
    temp_meas <= 16'sh6440;
    idle(2);
    wr(CMD_TEMP_FAULT, 8'h00, 16'hf8c9);
    idle(3);
    chk(ot_fault, 1'b0);
    temp_meas <= 16'sh6480;
    idle(3);
    chk(ot_fault, 1'b1);
    idle(2);
    chk(alert_b, 1'b0);
    rdchk(CMD_STATUS_TEMP, 8'h00, 16'h0080);
    rdchk(CMD_STATUS_BYTE, 8'h00, 16'h0004);
    temp_meas <= 16'shf600;
    idle(3);
    chk(ot_fault, 1'b0);
    wr(CMD_CLEAR_FAULTS, 8'h00, 16'h0000);
    wr(CMD_CUR_WARN, PHASE_ALL, 16'h0028);
    rdchk(CMD_CUR_WARN, 8'h02, 16'h000a);
    rdchk(CMD_CUR_WARN, PHASE_ALL, 16'h0028);
    wr(CMD_CUR_WARN, PHASE_ALL, 16'h005d);
    rdchk(CMD_STATUS_CML, 8'h00, 16'h0040);
    rdchk(CMD_STATUS_BYTE, 8'h00, 16'h0002);
    chk(alert_b, 1'b0);
    rdchk(CMD_CUR_WARN, PHASE_ALL, 16'h0028);
    wr(CMD_CUR_WARN, PHASE_ALL, 16'h005c);
    wr(CMD_CUR_WARN, 8'h01, 16'h0018);
    wr(CMD_TEMP_FAULT, 8'h00, 16'h00a1);
    rdchk(CMD_CUR_WARN, 8'h01, 16'h0017);
    rdchk(CMD_TEMP_FAULT, 8'h00, 16'hf8c9);
    wr(CMD_CLEAR_FAULTS, 8'h00, 16'h0000);
    wr(CMD_CUR_WARN, 8'h05, 16'h0005);
    rdchk(CMD_CUR_WARN, 8'h01, 16'h0017);
    rdchk(CMD_STATUS_CML, 8'h00, 16'h0040);
    wr(CMD_CLEAR_FAULTS, 8'h00, 16'h0000);
    phase_count <= 2'h1;
    idle(4);
    wr(CMD_CUR_WARN, 8'h03, 16'h0005);
    rdchk(CMD_STATUS_CML, 8'h00, 16'h0040);
    rdchk(CMD_CUR_WARN, PHASE_ALL, 16'h002e);
    phase_count <= 2'h3;
    wr(CMD_CLEAR_FAULTS, 8'h00, 16'h0000);
    wr(CMD_CUR_WARN, 8'h00, 16'he851);
    nvm_store <= 1'b1;
    idle(1);
    nvm_store <= 1'b0;
    idle(1);
    chk({nvm_write, nvm_cur_out, nvm_temp_out}, {1'b1, {3{7'd92}}, 7'd41, 8'd101});
    rdchk(CMD_CUR_WARN, 8'h00, 16'hf029);
    rdchk(CMD_CUR_WARN, 8'h01, 16'hf05c);
    rdchk(CMD_TEMP_FAULT, 8'h00, 16'h0065);
    nvm_cur_in <= {7'd0, 7'd4, 7'd17, 7'd92};
    nvm_temp_in <= 8'd160;
    nvm_restore <= 1'b1;
    idle(1);
    nvm_restore <= 1'b0;
    idle(3);
    chk(hw_step, {5'd4, 5'd4, 5'd5, 5'd23});
    rdchk(CMD_TEMP_FAULT, 8'h00, 16'h00a0);
    end_of_test();
  end
endmodule : test_ctl_limits
